// ---- hw/cpd_pkg.sv ----
// package: constants and carrier types for the correction frame deframer
`default_nettype none
package cpd_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CPD_CLK_HZ = 50_000_000;
	localparam int unsigned CPD_TIMEOUT_MS = 3000;
	localparam int unsigned CPD_TIMEOUT_CYC = (CPD_CLK_HZ / 1000) * CPD_TIMEOUT_MS;
	// ==========================================================
	// frame layout
	localparam logic [55:0] CPD_TAG = 56'h5b_5041_434b_425d; // bracketed tag
	localparam logic [3:0] CPD_TAG_LAST = 4'h6;
	localparam logic [7:0] CPD_STAR = 8'h2a;
	localparam logic [7:0] CPD_CR = 8'h0d;
	localparam logic [7:0] CPD_LF = 8'h0a;
	localparam logic [7:0] CPD_XOR_KEY = 8'h55;
	localparam logic [15:0] CPD_HDR_BYTES = 16'h000b; // 9 header + 2 payload
	localparam logic [15:0] CPD_MAX_DATA = 16'h0200; // 512 bytes
	localparam logic [15:0] CPD_MAX_LEN = CPD_MAX_DATA + CPD_HDR_BYTES;
	localparam logic [15:0] CPD_IDX_LEN_LO = 16'h0000;
	localparam logic [15:0] CPD_IDX_LEN_HI = 16'h0001;
	localparam logic [15:0] CPD_IDX_CPL_LO = 16'h0002;
	localparam logic [15:0] CPD_IDX_CPL_HI = 16'h0003;
	localparam logic [15:0] CPD_IDX_TIME_LO = 16'h0004;
	localparam logic [15:0] CPD_IDX_TIME_HI = 16'h0008;
	localparam logic [15:0] CPD_IDX_FMT = 16'h0009;
	localparam logic [15:0] CPD_IDX_PORT = 16'h000a;
	localparam logic [15:0] CPD_CRC_LAST = 16'h0003;
	localparam logic [15:0] CPD_CRC_POLY = 16'h1021;
	localparam logic [15:0] CPD_CRC_INIT = 16'h0000;
	// ==========================================================
	// parser states
	typedef enum logic [8:0] {
		CPD_HUNT = 9'h001,
		CPD_TAGS = 9'h002,
		CPD_BODY = 9'h004,
		CPD_STARS = 9'h008,
		CPD_CRCS = 9'h010,
		CPD_CRS = 9'h020,
		CPD_LFS = 9'h040,
		CPD_DRAIN = 9'h080,
		CPD_SPARE = 9'h100
	} cpd_state_t;
	// ==========================================================
	// decoded correction byte to the parsers
	typedef struct packed {
		logic valid;
		logic [7:0] fmt;
		logic [7:0] data;
	} cpd_corr_t;
endpackage : cpd_pkg
`default_nettype wire

// ---- hw/cpd_deframer.sv ----
// module: correction frame deframer, checks and decodes correction frames
`default_nettype none
// Function
// - payload is format code, port byte, then correction bytes.
// - unknown format frames are still accepted and forwarded.
// - one frame carries at most 512 correction bytes.
// - device XORs each correction byte with 0x55 before forwarding.
// - time-of-week header bytes are ignored.
// - week field checks length integrity, not a week count.
// - frames are accepted from any input port feeding this stream.
// - frame not finished in three seconds resets parser, drops contents.
// - wireless link loss mid-frame resets parser, drops contents.
module cpd_deframer
	import cpd_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = CPD_TIMEOUT_CYC,
	parameter logic [15:0] CRC_INIT = CPD_CRC_INIT
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic link_up,
	output cpd_corr_t corr,
	output logic frame_ok,
	output logic frame_drop,
	output logic busy
);
	// ==========================================================
	// helper functions
	// one CCITT step over a byte, msb first
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ CPD_CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	// ascii hex digit to {ok, nibble}, either case
	function automatic logic [4:0] hex_dec(input logic [7:0] b);
		logic [4:0] r;
		r = 5'h00;
		if (b >= 8'h30 && b <= 8'h39) begin
			r = {1'b1, b[3:0]};
		end else if ((b >= 8'h41 && b <= 8'h46) || (b >= 8'h61 && b <= 8'h66)) begin
			r = {1'b1, 4'(b[3:0] + 4'h9)};
		end
		return r;
	endfunction : hex_dec

	// ==========================================================
	// state
	cpd_state_t state_ff, nxt_state;
	logic [15:0] idx_ff, nxt_idx;
	logic [15:0] len_ff, nxt_len;
	logic [15:0] crc_ff, nxt_crc;
	logic [15:0] rxcrc_ff, nxt_rxcrc;
	logic [7:0] fmt_ff, nxt_fmt;
	logic [31:0] timer_ff, nxt_timer;
	logic link_s1_ff, link_s2_ff;
	cpd_corr_t corr_ff, nxt_corr;
	logic ok_ff, nxt_ok, drop_ff, nxt_drop, busy_ff;
	logic [7:0] mem [0:511];

	// ==========================================================
	// decode
	wire in_frame = (state_ff != CPD_HUNT) && (state_ff != CPD_DRAIN);
	wire timed_out = in_frame && (timer_ff >= TIMEOUT_CYC - 1);
	wire abort = timed_out || (in_frame && !link_s2_ff);
	wire [7:0] tag_byte = CPD_TAG[8 * (6 - int'(idx_ff[3:0])) +: 8];
	wire [15:0] crc_new = crc_step(crc_ff, rx_data);
	wire [15:0] cpl_rx = {rx_data, rxcrc_ff[7:0]};
	wire len_good = (len_ff >= CPD_HDR_BYTES) && (len_ff <= CPD_MAX_LEN);
	wire [4:0] hex = hex_dec(rx_data);
	wire [8:0] wr_addr = 9'(idx_ff - CPD_HDR_BYTES);
	wire wr_en = ce && !abort && rx_valid && (state_ff == CPD_BODY)
		&& (idx_ff >= CPD_HDR_BYTES);
	wire [15:0] data_cnt = len_ff - CPD_HDR_BYTES;

	// ==========================================================
	// next state and outputs
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_len = len_ff;
		nxt_crc = crc_ff;
		nxt_rxcrc = rxcrc_ff;
		nxt_fmt = fmt_ff;
		nxt_timer = in_frame ? timer_ff + 32'h0000_0001 : 32'h0000_0000;
		nxt_ok = 1'b0;
		nxt_drop = 1'b0;
		nxt_corr = '0;
		if (abort) begin
			nxt_state = CPD_HUNT;
			nxt_drop = 1'b1;
			nxt_timer = 32'h0000_0000; // no count past the limit
		end else begin
			case (state_ff)
			CPD_HUNT: begin
				// one byte stream, whatever port feeds it
				if (rx_valid && rx_data == CPD_TAG[55:48]) begin
					nxt_state = CPD_TAGS;
					nxt_idx = 16'h0001;
				end
			end
			CPD_TAGS: begin
				if (rx_valid) begin
					nxt_idx = idx_ff + 16'h0001;
					nxt_crc = CRC_INIT;
					if (rx_data != tag_byte) begin
						nxt_state = CPD_HUNT;
					end else if (idx_ff[3:0] == CPD_TAG_LAST) begin
						nxt_state = CPD_BODY;
						nxt_idx = 16'h0000;
					end
				end
			end
			CPD_BODY: begin
				if (rx_valid) begin
					nxt_crc = crc_new;
					nxt_idx = idx_ff + 16'h0001;
					if (idx_ff == CPD_IDX_LEN_LO) nxt_len[7:0] = rx_data;
					if (idx_ff == CPD_IDX_LEN_HI) nxt_len[15:8] = rx_data;
					if (idx_ff == CPD_IDX_CPL_LO) nxt_rxcrc[7:0] = rx_data;
					// time bytes and version fall through
					if (idx_ff == CPD_IDX_FMT) nxt_fmt = rx_data;
					if (idx_ff == CPD_IDX_CPL_HI && !(len_good && cpl_rx == ~len_ff)) begin
						nxt_state = CPD_HUNT;
						nxt_drop = 1'b1;
					end else if (idx_ff >= CPD_IDX_PORT && idx_ff == len_ff - 16'h0001) begin
						nxt_state = CPD_STARS;
					end
				end
			end
			CPD_STARS: begin
				if (rx_valid) begin
					nxt_idx = 16'h0000;
					nxt_state = (rx_data == CPD_STAR) ? CPD_CRCS : CPD_HUNT;
					nxt_drop = rx_data != CPD_STAR;
				end
			end
			CPD_CRCS: begin
				if (rx_valid) begin
					nxt_rxcrc = {rxcrc_ff[11:0], hex[3:0]};
					nxt_idx = idx_ff + 16'h0001;
					if (!hex[4]) begin
						nxt_state = CPD_HUNT;
						nxt_drop = 1'b1;
					end else if (idx_ff == CPD_CRC_LAST) begin
						nxt_state = CPD_CRS;
					end
				end
			end
			CPD_CRS: begin
				if (rx_valid) begin
					nxt_state = (rx_data == CPD_CR) ? CPD_LFS : CPD_HUNT;
					nxt_drop = rx_data != CPD_CR;
				end
			end
			CPD_LFS: begin
				if (rx_valid) begin
					nxt_idx = 16'h0000;
					if (rx_data != CPD_LF || rxcrc_ff != crc_ff) begin
						nxt_state = CPD_HUNT;
						nxt_drop = 1'b1;
					end else if (len_ff == CPD_HDR_BYTES) begin
						nxt_state = CPD_HUNT;
						nxt_ok = 1'b1;
					end else begin
						nxt_state = CPD_DRAIN;
					end
				end
			end
			CPD_DRAIN: begin
				// stored bytes already restored, any format code
				nxt_corr.valid = 1'b1;
				nxt_corr.fmt = fmt_ff;
				nxt_corr.data = mem[idx_ff[8:0]];
				nxt_idx = idx_ff + 16'h0001;
				if (idx_ff == data_cnt - 16'h0001) begin
					nxt_state = CPD_HUNT;
					nxt_ok = 1'b1;
				end
			end
			default: begin
				nxt_state = CPD_HUNT;
			end
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= CPD_HUNT;
			idx_ff <= 16'h0000;
			len_ff <= 16'h0000;
			crc_ff <= CPD_CRC_INIT;
			rxcrc_ff <= 16'h0000;
			fmt_ff <= 8'h00;
			timer_ff <= 32'h0000_0000;
			link_s1_ff <= 1'b0;
			link_s2_ff <= 1'b0;
			corr_ff <= '0;
			ok_ff <= 1'b0;
			drop_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			len_ff <= nxt_len;
			crc_ff <= nxt_crc;
			rxcrc_ff <= nxt_rxcrc;
			fmt_ff <= nxt_fmt;
			timer_ff <= nxt_timer;
			link_s1_ff <= link_up;
			link_s2_ff <= link_s1_ff;
			corr_ff <= nxt_corr;
			ok_ff <= nxt_ok;
			drop_ff <= nxt_drop;
			busy_ff <= nxt_state != CPD_HUNT;
		end
	end

	// payload store, restored on the way in
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= rx_data ^ CPD_XOR_KEY;
		end
	end

	assign corr = corr_ff;
	assign frame_ok = ok_ff;
	assign frame_drop = drop_ff;
	assign busy = busy_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	link_loss_drop_a: assert property (
		(ce && in_frame && !link_s2_ff) |=> (frame_drop && state_ff == CPD_HUNT))
		else $error("link loss did not drop frame");
	timeout_drop_a: assert property (
		(ce && timed_out) |=> (frame_drop && !corr.valid))
		else $error("timeout did not drop frame");
	timer_bound_a: assert property (
		timer_ff < TIMEOUT_CYC)
		else $error("frame timer overran");
	xor_restore_a: assert property (
		wr_en |=> mem[$past(wr_addr)] == ($past(rx_data) ^ CPD_XOR_KEY))
		else $error("stored byte not restored");
	cpl_check_a: assert property (
		(ce && rx_valid && state_ff == CPD_BODY && idx_ff == CPD_IDX_CPL_HI
		&& cpl_rx != ~len_ff) |=> (frame_drop && state_ff == CPD_HUNT))
		else $error("bad complement accepted");
	max_len_a: assert property (
		(ce && rx_valid && state_ff == CPD_BODY && idx_ff == CPD_IDX_CPL_HI
		&& len_ff > CPD_MAX_LEN) |=> frame_drop)
		else $error("overlong frame accepted");
	crc_reject_a: assert property (
		(ce && rx_valid && state_ff == CPD_LFS && rxcrc_ff != crc_ff)
		|=> (frame_drop && !corr.valid) ##1 !corr.valid)
		else $error("bad crc frame forwarded");
	crc_seed_a: assert property (
		(ce && rx_valid && state_ff == CPD_TAGS && idx_ff[3:0] == CPD_TAG_LAST
		&& rx_data == tag_byte && !abort)
		|=> (crc_ff == CRC_INIT && state_ff == CPD_BODY))
		else $error("crc not seeded at frame start");
	time_ignored_a: assert property (
		(ce && rx_valid && state_ff == CPD_BODY && idx_ff >= CPD_IDX_TIME_LO
		&& idx_ff <= CPD_IDX_TIME_HI) |=> ($stable(len_ff) && $stable(fmt_ff)))
		else $error("time byte changed header state");
	unknown_fmt_a: assert property (
		(ce && state_ff == CPD_DRAIN && fmt_ff == 8'h00)
		|=> (corr.valid && corr.fmt == 8'h00))
		else $error("unknown format not forwarded");
endmodule : cpd_deframer
`default_nettype wire

// ---- dv/cpd_host_model.sv ----
// host model: builds and sends correction frames byte by byte
`default_nettype none
module cpd_host_model
	import cpd_pkg::*;
(
	input wire logic ref_clk,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// raw correction bytes queued by the bench for the next frame
	logic [7:0] pay_q[$];

	// idle line at time zero
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end

	// one ccitt step, msb first
	function automatic logic [15:0] crc_upd(input logic [15:0] c,
		input logic [7:0] b);
		c ^= {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ CPD_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc_upd

	// ascii hex digit, upper or lower case letters
	function automatic logic [7:0] hex(input logic [3:0] n, input logic lc);
		return (n < 4'hA) ? 8'h30 + n : (lc ? 8'h57 : 8'h37) + n;
	endfunction : hex

	// whole frame or its first cut bytes, held back to back; bad 1 spoils complement, 2 the crc
	task automatic send(input logic [7:0] fmt, input int cut,
		input logic [1:0] bad);
		logic [7:0] f[$];
		logic [15:0] len;
		logic [15:0] crc;
		f = {};
		for (int i = 6; i >= 0; i--) f.push_back(CPD_TAG[i*8+:8]);
		len = 16'(pay_q.size()) + CPD_HDR_BYTES;
		f.push_back(len[7:0]);
		f.push_back(len[15:8]);
		f.push_back(~len[7:0] ^ {7'h00, bad == 2'd1});
		f.push_back(~len[15:8]);
		for (int i = 0; i < 4; i++) f.push_back(8'($urandom));
		f.push_back(8'h00);
		f.push_back(fmt);
		f.push_back(8'h00);
		foreach (pay_q[i]) f.push_back(pay_q[i] ^ CPD_XOR_KEY);
		crc = CPD_CRC_INIT;
		for (int i = 7; i < f.size(); i++) crc = crc_upd(crc, f[i]);
		crc ^= {15'h0000, bad == 2'd2};
		f.push_back(CPD_STAR);
		for (int i = 3; i >= 0; i--) f.push_back(hex(crc[i*4+:4], 1'($urandom)));
		f.push_back(CPD_CR);
		f.push_back(CPD_LF);
		// no command traffic is mixed into a frame
		for (int i = 0; i < f.size() && (cut < 0 || i < cut); i++) begin
			rx_valid <= 1'b1;
			rx_data <= f[i];
			@(posedge ref_clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send
endmodule : cpd_host_model
`default_nettype wire

// ---- dv/correction_pack_deframer_tb.sv ----
// testbench: random and corner frames through the correction deframer
`default_nettype none
module correction_pack_deframer_tb
	import cpd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TO = 2000;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic link_up = 1'b1;
	logic rx_valid;
	logic [7:0] rx_data;
	cpd_corr_t corr;
	logic frame_ok;
	logic frame_drop;
	logic busy;
	int err_count = 0;
	int checks = 0;
	int ok_n;
	int drop_n;
	int busy_n;
	logic [7:0] got_q[$];
	logic [7:0] got_fmt;
	// ==========================================================
	// design and host
	cpd_deframer #(.TIMEOUT_CYC(TO)) i_cpd_deframer (.ref_clk(ref_clk),
		.rstn(rstn), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data),
		.link_up(link_up), .corr(corr), .frame_ok(frame_ok),
		.frame_drop(frame_drop), .busy(busy));
	cpd_host_model i_cpd_host_model (.ref_clk(ref_clk),
		.rx_valid(rx_valid), .rx_data(rx_data));

	// 50 MHz clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// collect forwarded bytes and frame outcomes where outputs have settled
	always @(negedge ref_clk) begin
		if (busy === 1'b1) busy_n++;
		if (corr.valid === 1'b1) begin
			got_q.push_back(corr.data);
			got_fmt = corr.fmt;
		end
		if (frame_ok === 1'b1) ok_n++;
		if (frame_drop === 1'b1) drop_n++;
	end

	// ==========================================================
	// checking and ending
	task automatic chk(input string nm, input logic [15:0] ex,
		input logic [15:0] got);
		checks++;
		if (got !== ex) begin
			$display("Error %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// fill payload, send all or cut, wait for an outcome
	task automatic frame(input logic [7:0] fmt, input int n, input int cut,
		input logic [1:0] bad, output int c);
		i_cpd_host_model.pay_q = {};
		for (int i = 0; i < n; i++) i_cpd_host_model.pay_q.push_back(8'($urandom));
		got_q = {};
		ok_n = 0;
		drop_n = 0;
		busy_n = 0;
		i_cpd_host_model.send(fmt, cut, bad);
		if (cut >= 0) link_up <= (bad != 2'd3);
		// a frozen parser must not age the cut frame
		if (bad == 2'd0 && cut >= 0) begin
			ce <= 1'b0;
			repeat (100) @(posedge ref_clk);
			ce <= 1'b1;
		end
		c = 0;
		while (ok_n + drop_n == 0 && c < 3 * TO) begin
			@(posedge ref_clk);
			c++;
		end
		repeat (4) @(posedge ref_clk);
		link_up <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : frame

	// busy span: tag after its first byte, header, data, trailer, drain
	function automatic int exp_busy(input int n);
		return 6 + int'(CPD_HDR_BYTES) + n + 7 + n;
	endfunction : exp_busy

	// good frame: every byte restored, format passed, one frame_ok
	task automatic good(input logic [7:0] fmt, input int n);
		int c;
		frame(fmt, n, -1, 2'd0, c);
		chk("frame_ok", 16'd1, 16'(ok_n));
		chk("frame_drop", 16'd0, 16'(drop_n));
		chk("busy cycles", 16'(exp_busy(n)), 16'(busy_n));
		chk("corr count", 16'(n), 16'(got_q.size()));
		for (int i = 0; i < n && i < got_q.size(); i++)
			chk("corr.data", i_cpd_host_model.pay_q[i], got_q[i]);
		if (n > 0) chk("corr.fmt", fmt, got_fmt);
		$display("good frame fmt %0d len %0d done", fmt, n);
	endtask : good

	// spoiled frame: one drop, nothing forwarded
	task automatic bad_frame(input logic [1:0] bad, input int cut,
		input int lo, input int hi, input int n);
		int c;
		frame(8'h03, n, cut, bad, c);
		chk("frame_drop", 16'd1, 16'(drop_n));
		chk("corr count", 16'd0, 16'(got_q.size()));
		chk("drop delay ok", 16'd1, 16'(c >= lo && c <= hi));
		$display("bad frame kind %0d done", bad);
	endtask : bad_frame

	// ==========================================================
	// watchdog
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		give_verdict();
	end

	// main sequence
	initial begin
		void'($urandom(32'hf282));
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int f = 0; f < 5; f++) good(8'(f), 1 + ($urandom % 40));
		good(8'h02, 0);
		good(8'h03, 512);
		bad_frame(2'd1, -1, 0, 0, 16);
		bad_frame(2'd2, -1, 1, 3, 16);
		bad_frame(2'd0, 20, TO - 40, TO, 16);
		bad_frame(2'd3, 20, 1, 8, 16);
		bad_frame(2'd0, -1, 0, 0, 513);
		good(8'h01, 1 + ($urandom % 40));
		give_verdict();
	end
endmodule : correction_pack_deframer_tb
`default_nettype wire
